// ---- core/rea_accum.sv ----
`timescale 1ns/1ps
`default_nettype none
module rea_accum (
	input  wire logic                 CLK,
	input  wire logic                 RESET,
	input  wire logic                 CE,
	input  wire rea_pkg::rea_wb_req_s WB_REQ,
	output var  rea_pkg::rea_wb_rsp_s WB_RSP,
	input  wire logic signed [23:0]   POWER_IN,
	input  wire logic                 INTEGRATOR_EN,
	input  wire logic                 ACTIVE_NEG,
	input  wire logic                 ENERGY_PULSE,
	output logic signed [25:0]        ENERGY_STEP,
	output logic signed [24:0]        WAVE_SAMPLE,
	output logic                      WAVE_VALID,
	output logic                      IRQ_PENDING
);
	import rea_pkg::*;

	typedef struct packed {
		logic               ack;
		logic [31:0]        rdat;
		logic [7:0]         wave_cfg;
		logic [7:0]         nl_cfg;
		logic [7:0]         acc_cfg;
		logic [7:0]         gain_cfg;
		logic [7:0]         en_lo;
		logic [7:0]         en_hi;
		logic [7:0]         st_lo;
		logic [15:0]        offset;
		logic [7:0]         divider;
		logic signed [48:0] acc;
		logic [2:0]         tick_cnt;
		logic               prev_neg;
		logic [11:0]        wave_cnt;
		logic signed [24:0] wave;
		logic               wave_vld;
		logic signed [25:0] step;
		logic               irq;
	} rea_state_s;

	rea_state_s s_reg;
	rea_state_s s_next;

	function automatic logic [24:0] rea_mag(input logic signed [24:0] v);
		rea_mag = v[24] ? 25'(-v) : 25'(v);
	endfunction : rea_mag

	function automatic logic [24:0] rea_thr(input logic [1:0] code);
		case (code)
			2'h1: rea_thr = 25'(NL_FS * NL_PPM1 / 1_000_000);
			2'h2: rea_thr = 25'(NL_FS * NL_PPM2 / 1_000_000);
			2'h3: rea_thr = 25'(NL_FS * NL_PPM3 / 1_000_000);
			default: rea_thr = 25'h0000000;
		endcase
	endfunction : rea_thr

	logic signed [23:0] raw;
	logic signed [32:0] ext;
	logic signed [24:0] samp;
	logic [24:0]        mag;
	logic [24:0]        thr;
	logic               below;
	logic [7:0]         dv;
	logic [24:0]        quo;
	logic signed [25:0] sq;
	logic signed [25:0] stp;
	logic signed [48:0] acc_add;
	logic               tick;
	logic               cur_neg;
	logic               chk;
	logic [7:0]         st_set;
	logic [7:0]         st_clr;
	logic [7:0]         idx;
	logic               req;
	logic               done;
	logic               wr;
	logic [31:0]        rd;
	logic [1:0]         wsrc;
	logic [11:0]        wper;
	logic [23:0]        e_old;
	logic [23:0]        e_new;

	always_comb begin
		s_next = s_reg;
		st_set = 8'h00;
		st_clr = 8'h00;
		// Integrated current already lags, so the filter flips to -90 deg
		raw = INTEGRATOR_EN ? 24'(-POWER_IN) : POWER_IN;
		// Negating zero must not flip the sign bit of the widened sample
		ext = 33'({POWER_IN[23] ^ (INTEGRATOR_EN && (|POWER_IN)),
			raw, 8'h00}) + 33'(signed'(s_reg.offset));
		samp = ext[32:8];
		mag = rea_mag(samp);
		thr = rea_thr(s_reg.nl_cfg[NL_LSB +: 2]);
		below = (thr != 25'h0000000) && (mag < thr);
		dv = (s_reg.divider == 8'h00) ? 8'h01 : s_reg.divider;
		quo = 25'(mag / {17'h00000, dv});
		sq = samp[24] ? 26'(-signed'({1'b0, quo})) : 26'({1'b0, quo});
		if (s_reg.acc_cfg[ACC_ABS_BIT]) begin
			stp = 26'({1'b0, quo});
		end else if (s_reg.acc_cfg[ACC_ANTI_BIT] && ACTIVE_NEG) begin
			stp = 26'(-sq);
		end else begin
			stp = sq;
		end
		s_next.step = stp;
		tick = (s_reg.tick_cnt == 3'(ACC_PERIOD - 1));
		s_next.tick_cnt = tick ? 3'h0 : 3'(s_reg.tick_cnt + 3'h1);
		acc_add = s_reg.acc + 49'(stp);
		e_old = s_reg.acc[48:25];
		e_new = acc_add[48:25];
		if (tick && !below) begin
			s_next.acc = acc_add;
			if ((e_new[23:22] == 2'h1 || e_new[23:22] == 2'h2)
				&& e_new[23:22] != e_old[23:22]) begin
				st_set[ST_HALF] = 1'b1;
			end
			if (s_reg.acc[48] == stp[25] && acc_add[48] != stp[25]) begin
				st_set[ST_OVF] = 1'b1;
			end
		end
		if (tick && below) begin
			st_set[ST_NOLOAD] = 1'b1;
		end
		// Option picks the pulse edge or the filtered stream as sampler
		chk = s_reg.gain_cfg[GAIN_OPT_BIT] ? ENERGY_PULSE : tick;
		cur_neg = s_reg.gain_cfg[GAIN_OPT_BIT] ? stp[25] : samp[24];
		if (chk) begin
			s_next.prev_neg = cur_neg;
			if (cur_neg != s_reg.prev_neg
				&& cur_neg != s_reg.acc_cfg[ACC_DIR_BIT]) begin
				st_set[ST_SIGN] = 1'b1;
			end
		end
		wsrc = s_reg.wave_cfg[1:0];
		case (s_reg.wave_cfg[WAVE_RATE_LSB +: 2])
			2'h0: wper = WAVE_CYC0;
			2'h1: wper = WAVE_CYC1;
			2'h2: wper = WAVE_CYC2;
			default: wper = WAVE_CYC3;
		endcase
		s_next.wave_vld = 1'b0;
		if (s_reg.en_hi[WAVEFORM_SAMPLE_ENABLE_BIT] && wsrc == WAVE_SRC_REACTIVE) begin
			if (s_reg.wave_cnt >= wper - 12'h001) begin
				s_next.wave_cnt = 12'h000;
				s_next.wave = samp;
				s_next.wave_vld = 1'b1;
			end else begin
				s_next.wave_cnt = s_reg.wave_cnt + 12'h001;
			end
		end else begin
			s_next.wave_cnt = 12'h000;
		end
		// Wishbone: ack one cycle after the strobe, effects at ack edge
		idx = WB_REQ.adr[9:2];
		req = WB_REQ.cyc && WB_REQ.stb;
		done = req && s_reg.ack;
		wr = done && WB_REQ.we;
		s_next.ack = req && !s_reg.ack;
		case (idx)
			IDX_WAVE:      rd = {24'h000000, s_reg.wave_cfg};
			IDX_NOLOAD:    rd = {24'h000000, s_reg.nl_cfg};
			IDX_ACCCFG:    rd = {24'h000000, s_reg.acc_cfg};
			IDX_GAIN:      rd = {24'h000000, s_reg.gain_cfg};
			IDX_IRQEN_LO:  rd = {24'h000000, s_reg.en_lo};
			IDX_IRQEN_HI:  rd = {24'h000000, s_reg.en_hi};
			IDX_IRQST_LO:  rd = {24'h000000, s_reg.st_lo};
			IDX_OFFSET:    rd = {16'h0000, s_reg.offset};
			IDX_ENERGY:    rd = {8'h00, e_old};
			IDX_ENERGY_RC: rd = {8'h00, e_old};
			IDX_DIVIDER:   rd = {24'h000000, s_reg.divider};
			default:       rd = 32'h00000000;
		endcase
		if (WB_REQ.adr[1:0] != 2'h0) begin
			rd = 32'h00000000;
		end
		s_next.rdat = (req && !s_reg.ack) ? rd : 32'h00000000;
		if (wr && WB_REQ.adr[1:0] == 2'h0 && WB_REQ.sel[0]) begin
			case (idx)
				IDX_WAVE:     s_next.wave_cfg = WB_REQ.dat[7:0];
				IDX_NOLOAD:   s_next.nl_cfg = WB_REQ.dat[7:0];
				IDX_ACCCFG:   s_next.acc_cfg = WB_REQ.dat[7:0];
				IDX_GAIN:     s_next.gain_cfg = WB_REQ.dat[7:0];
				IDX_IRQEN_LO: s_next.en_lo = WB_REQ.dat[7:0];
				IDX_IRQEN_HI: s_next.en_hi = WB_REQ.dat[7:0];
				IDX_IRQST_LO: st_clr = WB_REQ.dat[7:0];
				IDX_OFFSET:   s_next.offset[7:0] = WB_REQ.dat[7:0];
				IDX_DIVIDER:  s_next.divider = WB_REQ.dat[7:0];
				default:      st_clr = 8'h00;
			endcase
		end
		if (wr && WB_REQ.adr[1:0] == 2'h0 && WB_REQ.sel[1]
			&& idx == IDX_OFFSET) begin
			s_next.offset[15:8] = WB_REQ.dat[15:8];
		end
		// Clearing the top keeps the sub-LSB residue; carries from ticks at the strobe and ack edges are dropped
		if (done && !WB_REQ.we && WB_REQ.adr[1:0] == 2'h0
			&& idx == IDX_ENERGY_RC) begin
			s_next.acc[48:25] = 24'h000000;
		end
		// A new event beats a clear landing in the same cycle
		s_next.st_lo = (s_reg.st_lo & ~st_clr) | st_set;
		s_next.irq = |(s_next.st_lo & s_next.en_lo);
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			s_reg <= '0;
			s_reg.wave_cfg <= RST_BYTE;
			s_reg.nl_cfg <= RST_BYTE;
			s_reg.acc_cfg <= RST_BYTE;
			s_reg.offset <= RST_OFFSET;
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	assign WB_RSP.ack = s_reg.ack;
	assign WB_RSP.dat = s_reg.rdat;
	assign ENERGY_STEP = s_reg.step;
	assign WAVE_SAMPLE = s_reg.wave;
	assign WAVE_VALID = s_reg.wave_vld;
	assign IRQ_PENDING = s_reg.irq;

	property p_ack_pulse;
		@(posedge CLK) disable iff (RESET)
		s_reg.ack && CE |=> !s_reg.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");

	property p_tick_only;
		@(posedge CLK) disable iff (RESET)
		CE && !tick && !done |=> $stable(s_reg.acc);
	endproperty
	a_tick_only: assert property (p_tick_only)
		else $error("accumulator moved off the five-cycle tick");

	property p_noload_hold;
		@(posedge CLK) disable iff (RESET)
		CE && tick && below && !done |=> $stable(s_reg.acc);
	endproperty
	a_noload_hold: assert property (p_noload_hold)
		else $error("accumulated below no-load threshold");

	property p_noload_flag;
		@(posedge CLK) disable iff (RESET)
		CE && tick && below |=> s_reg.st_lo[ST_NOLOAD];
	endproperty
	a_noload_flag: assert property (p_noload_flag)
		else $error("no-load flag not set");

	property p_sign_fall;
		@(posedge CLK) disable iff (RESET)
		CE && chk && !s_reg.acc_cfg[ACC_DIR_BIT] && !s_reg.prev_neg
		&& cur_neg |=> s_reg.st_lo[ST_SIGN];
	endproperty
	a_sign_fall: assert property (p_sign_fall)
		else $error("positive to negative change missed");

	property p_irq_sign;
		@(posedge CLK) disable iff (RESET)
		s_reg.st_lo[ST_SIGN] && s_reg.en_lo[ST_SIGN] |-> IRQ_PENDING;
	endproperty
	a_irq_sign: assert property (p_irq_sign)
		else $error("sign interrupt not pending");

	property p_rc_clear;
		@(posedge CLK) disable iff (RESET)
		CE && done && !WB_REQ.we && WB_REQ.adr == {IDX_ENERGY_RC, 2'h0}
		|=> s_reg.acc[48:25] == 24'h000000;
	endproperty
	a_rc_clear: assert property (p_rc_clear)
		else $error("read-clear left energy bits");

	property p_wave_gap;
		@(posedge CLK) disable iff (RESET)
		WAVE_VALID |=> !WAVE_VALID [*8];
	endproperty
	a_wave_gap: assert property (p_wave_gap)
		else $error("waveform samples too close");

	property p_sign_rise;
		@(posedge CLK) disable iff (RESET)
		CE && chk && s_reg.acc_cfg[ACC_DIR_BIT] && s_reg.prev_neg
		&& !cur_neg |=> s_reg.st_lo[ST_SIGN];
	endproperty
	a_sign_rise: assert property (p_sign_rise)
		else $error("negative to positive change missed");

	property p_irq_noload;
		@(posedge CLK) disable iff (RESET)
		s_reg.st_lo[ST_NOLOAD] && s_reg.en_lo[ST_NOLOAD] |-> IRQ_PENDING;
	endproperty
	a_irq_noload: assert property (p_irq_noload)
		else $error("no-load interrupt not pending");

	property p_nl_off;
		@(posedge CLK) disable iff (RESET)
		s_reg.nl_cfg[NL_LSB +: 2] == 2'h0 |-> !below;
	endproperty
	a_nl_off: assert property (p_nl_off)
		else $error("no-load detected while disabled");

	property p_nl_small;
		@(posedge CLK) disable iff (RESET)
		s_reg.nl_cfg[NL_LSB +: 2] != 2'h0
		&& mag < 25'h0000100 |-> below;
	endproperty
	a_nl_small: assert property (p_nl_small)
		else $error("tiny sample not treated as no-load");

	property p_div_one;
		@(posedge CLK) disable iff (RESET)
		s_reg.divider == 8'h00 |-> quo == mag;
	endproperty
	a_div_one: assert property (p_div_one)
		else $error("zero divider did not divide by one");

	property p_abs_mag;
		@(posedge CLK) disable iff (RESET)
		s_reg.acc_cfg[ACC_ABS_BIT] |-> !stp[25] && stp == 26'(quo);
	endproperty
	a_abs_mag: assert property (p_abs_mag)
		else $error("absolute mode step not a magnitude");

	property p_anti_flip;
		@(posedge CLK) disable iff (RESET)
		!s_reg.acc_cfg[ACC_ABS_BIT] && s_reg.acc_cfg[ACC_ANTI_BIT]
		&& ACTIVE_NEG && quo != 25'h0000000 |-> stp[25] != samp[24];
	endproperty
	a_anti_flip: assert property (p_anti_flip)
		else $error("anti-tamper step not inverted");

	property p_signed_keep;
		@(posedge CLK) disable iff (RESET)
		s_reg.acc_cfg[ACC_ABS_BIT:ACC_ANTI_BIT] == 2'h0
		&& quo != 25'h0000000 |-> stp[25] == samp[24];
	endproperty
	a_signed_keep: assert property (p_signed_keep)
		else $error("signed mode step changed sign");

	property p_offset_lsb;
		@(posedge CLK) disable iff (RESET)
		!INTEGRATOR_EN && s_reg.offset == 16'h0100
		|-> samp == {POWER_IN[23], POWER_IN} + 25'h0000001;
	endproperty
	a_offset_lsb: assert property (p_offset_lsb)
		else $error("offset of 256 did not add one sample LSB");
endmodule : rea_accum
`default_nettype wire

// ---- core/rea_pkg.sv ----
// Behaviour
// - Add signed 16-bit offset to reactive power before integration.
// - Offset of 256 counts moves the power sample by one LSB.
// - Filter shifts -90 deg with integrator on, +90 deg with it off.
// - Reactive power is signed: positive 0..90 deg, negative -90..0 deg.
// - Sign detect watches filtered power or each pulse, per option bit.
// - Direction bit clear: flag set on positive to negative change.
// - Direction bit set: flag set on negative to positive change.
// - Sign flag with enable set holds interrupt request until cleared.
// - No accumulation while power is below the no-load threshold.
// - Below threshold sets no-load flag; enabled flag holds request.
// - Threshold code 00 off; 01,10,11 pick 0.015, 0.0075, 0.0037 pct.
// - 49-bit signed hidden accumulator; energy register is top 24 bits.
// - One sample added every 5 clock cycles.
// - Mode bits clear: signed sum; both set: absolute mode.
// - Anti-tamper: add if active power positive, subtract if negative.
// - Absolute mode sums magnitude, still skipping no-load samples.
// - Divide power by 8-bit divider; zero divides by one.
// - Read-clear register returns energy then zeroes top 24 bits.
// - Energy wraps to 0x800000 positive, to 0x7FFFFF negative.
// - Enableable flags for energy half full and overflow/underflow.
// - Waveform output of reactive power at 27.9, 14, 7 or 3.5 kSPS.
// - Signed accumulation after reset.
package rea_pkg;
	localparam int CLK_HZ        = 10_000_000;
	localparam int ACC_PERIOD    = 5;
	localparam int WAVE_HZ0      = 27_900;
	localparam int WAVE_HZ1      = 14_000;
	localparam int WAVE_HZ2      = 7_000;
	localparam int WAVE_HZ3      = 3_500;
	localparam logic [11:0] WAVE_CYC0 = 12'(CLK_HZ / WAVE_HZ0);
	localparam logic [11:0] WAVE_CYC1 = 12'(CLK_HZ / WAVE_HZ1);
	localparam logic [11:0] WAVE_CYC2 = 12'(CLK_HZ / WAVE_HZ2);
	localparam logic [11:0] WAVE_CYC3 = 12'(CLK_HZ / WAVE_HZ3);
	// Thresholds in parts per million of the 2^23 full scale
	localparam longint NL_FS     = 64'h800000;
	localparam longint NL_PPM1   = 150;
	localparam longint NL_PPM2   = 75;
	localparam longint NL_PPM3   = 37;
	localparam logic [7:0] IDX_WAVE     = 8'h0D;
	localparam logic [7:0] IDX_NOLOAD   = 8'h0E;
	localparam logic [7:0] IDX_ACCCFG   = 8'h0F;
	localparam logic [7:0] IDX_GAIN     = 8'h1B;
	localparam logic [7:0] IDX_IRQEN_LO = 8'hD9;
	localparam logic [7:0] IDX_IRQEN_HI = 8'hDB;
	localparam logic [7:0] IDX_IRQST_LO = 8'hDC;
	localparam logic [7:0] IDX_OFFSET   = 8'hE0;
	localparam logic [7:0] IDX_ENERGY   = 8'hE1;
	localparam logic [7:0] IDX_ENERGY_RC = 8'hE2;
	localparam logic [7:0] IDX_DIVIDER  = 8'hE3;
	localparam int ACC_ANTI_BIT  = 0;
	localparam int ACC_ABS_BIT   = 1;
	localparam int ACC_DIR_BIT   = 2;
	localparam int GAIN_OPT_BIT  = 7;
	localparam int NL_LSB        = 2;
	localparam int WAVE_RATE_LSB = 2;
	localparam logic [1:0] WAVE_SRC_REACTIVE = 2'h3;
	localparam int WAVEFORM_SAMPLE_ENABLE_BIT      = 0;
	localparam int ST_SIGN       = 0;
	localparam int ST_NOLOAD     = 1;
	localparam int ST_HALF       = 2;
	localparam int ST_OVF        = 3;
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_OFFSET = 16'h0000;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [9:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} rea_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} rea_wb_rsp_s;
endpackage : rea_pkg

// ---- verification/rea_accum_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rea_accum_tb;
	import rea_pkg::*;
	logic               CLK = 1'b0;
	logic               RESET = 1'b1;
	logic               CE = 1'b1;
	rea_wb_req_s        wb_req = '0;
	rea_wb_rsp_s        wb_rsp;
	logic signed [23:0] power = '0;
	logic               act_neg = 1'b0;
	logic               integ = 1'b0;
	logic               pulse = 1'b0;
	logic signed [25:0] step;
	logic signed [24:0] wave;
	logic               wave_vld;
	logic               irq;
	logic [31:0]        rd;
	int                 mismatches = 0;
	int                 n_compared = 0;

	always #50 CLK = ~CLK;

	rea_accum rea_accum_inst (
		.CLK(CLK), .RESET(RESET), .CE(CE), .WB_REQ(wb_req), .WB_RSP(wb_rsp),
		.POWER_IN(power), .INTEGRATOR_EN(integ), .ACTIVE_NEG(act_neg),
		.ENERGY_PULSE(pulse), .ENERGY_STEP(step), .WAVE_SAMPLE(wave),
		.WAVE_VALID(wave_vld), .IRQ_PENDING(irq)
	);

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Request held until ack is sampled high at a rising edge
	task automatic wb(input logic we, input logic [7:0] idx,
			input logic [31:0] d);
		int n;
		n = 0;
		wb_req <= '{1'b1, 1'b1, we, {idx, 2'h0}, 4'hF, d};
		do begin
			@(posedge CLK);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			close_out();
		end
		rd = wb_rsp.dat;
		wb_req <= '0;
		@(posedge CLK);
	endtask : wb

	task automatic t_regs;
		wb(0, IDX_ACCCFG, 0);   check("acc cfg reset", 0, rd);
		wb(0, IDX_DIVIDER, 0);  check("divider reset", 0, rd);
		wb(0, IDX_OFFSET, 0);   check("offset reset", 0, rd);
		wb(1, 8'h10, 32'hFF);
		wb(0, 8'h10, 0);        check("unmapped", 0, rd);
		wb(1, IDX_ACCCFG, 5);
		wb(0, IDX_ACCCFG, 0);   check("acc cfg rw", 5, rd);
		$display("done regs");
	endtask : t_regs

	task automatic t_step(input logic [7:0] dv, input logic [15:0] os,
			input int p, input logic [7:0] cf, input logic ng, input int e);
		wb(1, IDX_DIVIDER, dv);
		wb(1, IDX_OFFSET, os);
		wb(1, IDX_ACCCFG, cf);
		power <= 24'(p);
		act_neg <= ng;
		repeat (30) @(posedge CLK);
		check("energy step", e, 32'(step));
		$display("done step");
	endtask : t_step

	// Flow in one direction, then read-clear; power parked at zero first
	task automatic t_energy(input logic [7:0] cf, input int p,
			input logic neg_exp);
		logic [31:0] e1;
		wb(1, IDX_ACCCFG, cf);
		power <= '0;
		repeat (10) @(posedge CLK);
		wb(0, IDX_ENERGY_RC, 0);
		power <= 24'(p);
		repeat (200) @(posedge CLK);
		power <= '0;
		repeat (10) @(posedge CLK);
		wb(0, IDX_ENERGY, 0);
		check("energy sign", 32'(neg_exp), 32'(rd[23]));
		check("energy nonzero", 1, 32'(rd != 0));
		e1 = rd;
		wb(0, IDX_ENERGY_RC, 0);
		check("read clear value", e1, rd);
		wb(0, IDX_ENERGY, 0);   check("after clear", 0, rd);
		$display("done energy");
	endtask : t_energy

	task automatic t_sign(input logic dir);
		wb(1, IDX_ACCCFG, {5'h0, dir, 2'h0});
		wb(1, IDX_IRQEN_LO, 8'h01);
		power <= 24'sh001000;
		repeat (40) @(posedge CLK);
		wb(1, IDX_IRQST_LO, 8'h0F);
		power <= -24'sh001000;
		repeat (40) @(posedge CLK);
		wb(0, IDX_IRQST_LO, 0);
		check("sign pos to neg", 32'(!dir), 32'(rd[0]));
		check("irq pos to neg", 32'(!dir), 32'(irq));
		wb(1, IDX_IRQST_LO, 8'h0F);
		check("irq cleared", 0, 32'(irq));
		power <= 24'sh001000;
		repeat (40) @(posedge CLK);
		wb(0, IDX_IRQST_LO, 0);
		check("sign neg to pos", 32'(dir), 32'(rd[0]));
		wb(1, IDX_IRQST_LO, 8'h0F);
		$display("done sign");
	endtask : t_sign

	task automatic t_noload;
		wb(1, IDX_NOLOAD, 8'h04);
		wb(1, IDX_IRQEN_LO, 8'h02);
		wb(1, IDX_ACCCFG, 0);
		power <= 24'sh000064;
		repeat (10) @(posedge CLK);
		wb(0, IDX_ENERGY_RC, 0);
		wb(1, IDX_IRQST_LO, 8'h0F);
		repeat (100) @(posedge CLK);
		wb(0, IDX_IRQST_LO, 0);
		check("noload flag", 1, 32'(rd[ST_NOLOAD]));
		check("noload irq", 1, 32'(irq));
		wb(0, IDX_ENERGY, 0);   check("no creep", 0, rd);
		wb(1, IDX_NOLOAD, 8'h00);
		wb(1, IDX_IRQEN_LO, 8'h00);
		$display("done noload");
	endtask : t_noload

	task automatic t_wave;
		int n;
		wb(1, IDX_WAVE, {4'h0, 2'h0, WAVE_SRC_REACTIVE});
		wb(1, IDX_IRQEN_HI, 8'h01);
		power <= 24'sh001234;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (wave_vld !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			mismatches++;
			close_out();
		end
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (wave_vld !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			mismatches++;
			close_out();
		end
		check("wave period", 32'(WAVE_CYC0), 32'(n));
		check("wave sample", 32'h1234, 32'(wave));
		wb(1, IDX_IRQEN_HI, 8'h00);
		$display("done wave");
	endtask : t_wave

	// State must hold while the clock enable is low
	task automatic t_freeze;
		wb(1, IDX_ACCCFG, 0);
		power <= 24'sh001000;
		repeat (10) @(posedge CLK);
		CE <= 1'b0;
		power <= 24'sh002000;
		repeat (10) @(posedge CLK);
		check("step frozen", 32'h1000, 32'(step));
		CE <= 1'b1;
		repeat (3) @(posedge CLK);
		check("step resumed", 32'h2000, 32'(step));
		$display("done freeze");
	endtask : t_freeze

	task automatic t_integ;
		wb(1, IDX_ACCCFG, 0);
		integ <= 1'b1;
		power <= '0;
		repeat (10) @(posedge CLK);
		check("integrator zero", 0, 32'(step));
		power <= 24'sh001000;
		repeat (10) @(posedge CLK);
		check("integrator flip", -32'sh1000, 32'(step));
		integ <= 1'b0;
		power <= '0;
		repeat (10) @(posedge CLK);
		$display("done integrator");
	endtask : t_integ

	// With the option set only a pulse may sample the sign
	task automatic t_pulse_sign;
		wb(1, IDX_ACCCFG, 0);
		wb(1, IDX_IRQEN_LO, 8'h01);
		power <= 24'sh001000;
		repeat (20) @(posedge CLK);
		wb(1, IDX_GAIN, 8'h80);
		wb(1, IDX_IRQST_LO, 8'h0F);
		power <= -24'sh001000;
		repeat (40) @(posedge CLK);
		wb(0, IDX_IRQST_LO, 0);
		check("no sign without pulse", 0, 32'(rd[ST_SIGN]));
		pulse <= 1'b1;
		@(posedge CLK);
		pulse <= 1'b0;
		repeat (5) @(posedge CLK);
		wb(0, IDX_IRQST_LO, 0);
		check("sign at pulse", 1, 32'(rd[ST_SIGN]));
		wb(1, IDX_GAIN, 8'h00);
		wb(1, IDX_IRQST_LO, 8'h0F);
		$display("done pulse sign");
	endtask : t_pulse_sign

	initial begin
		repeat (20) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		t_regs();
		t_step(0, 0, 32'h1000, 0, 0, 32'h1000);
		t_step(4, 0, 32'h1000, 0, 0, 32'h400);
		t_step(1, 16'h0100, 32'h1000, 0, 0, 32'h1001);
		t_step(1, 0, -32'h1000, 0, 0, -32'h1000);
		t_step(1, 0, 32'h1000, 1, 1, -32'h1000);
		t_step(1, 0, -32'h1000, 2, 0, 32'h1000);
		t_step(1, 0, -32'h1000, 3, 0, 32'h1000);
		wb(1, IDX_OFFSET, 0);
		t_freeze();
		t_integ();
		act_neg <= 1'b0;
		t_energy(8'h00, 32'h400000, 0);
		t_energy(8'h00, -32'h400000, 1);
		t_energy(8'h02, -32'h400000, 0);
		t_sign(1'b0);
		t_sign(1'b1);
		t_pulse_sign();
		t_noload();
		t_wave();
		close_out();
	end
endmodule : rea_accum_tb
`default_nettype wire
